// file: rtl/stsc_top.sv
`timescale 1ns/1ps
`default_nettype none

module stsc_top
    import stsc_pkg::*;
(
    // clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_nrst,
    // microprocessor bus
    input  wire logic         i_addr_latch_strobe,
    input  wire logic         i_chip_sel_n,
    input  wire logic         i_read_strobe_n,
    input  wire logic         i_store_strobe_n,
    input  wire logic [7:0]   i_muxed_bus,
    output logic [7:0]        o_muxed_bus,
    output logic              o_muxed_bus_oe_n,
    // servo comparators
    input  wire stsc_cmp_type i_cmp,
    // outputs
    output logic              o_crossing_irq_n,
    output logic              o_outside_threshold_n,
    output logic              o_outside_threshold_oe_n,
    output logic              o_track_not_seek,
    output stsc_ctl_type      o_ctl
);

    // bus state
    logic       ale_q, ale_d;
    logic [2:0] addr_q, addr_d;
    logic       rd_q, rd_d;
    logic       wr_q, wr_d;
    logic [7:0] rdata_q, rdata_d;
    logic       oe_n_q, oe_n_d;

    // register state
    logic [7:0] thresh_q, thresh_d;
    logic [7:0] stctl_q, stctl_d;
    logic [7:0] trim_q, trim_d;
    logic       cross_q, cross_d;

    // comparator synchronisers and edge history
    logic [1:0] quad_s1_q, quad_s1_d;
    logic [1:0] quad_s2_q, quad_s2_d;
    logic [1:0] quad_h_q, quad_h_d;
    logic       win_s1_q, win_s1_d;
    logic       win_s2_q, win_s2_d;
    logic       neg_s1_q, neg_s1_d;
    logic       neg_s2_q, neg_s2_d;

    // output flops
    logic         irq_n_q, irq_n_d;
    logic         out_n_q, out_n_d;
    logic         mode_q, mode_d;
    stsc_ctl_type ctl_q, ctl_d;

    logic       rd_start;
    logic       wr_end;
    logic       cross_evt;
    logic [7:0] status_val;

    always_comb begin
        ale_d = i_addr_latch_strobe;
        addr_d = addr_q;
        if (ale_q && !i_addr_latch_strobe) begin
            addr_d = i_muxed_bus[2:0];
        end
        rd_d = !i_chip_sel_n && !i_read_strobe_n;
        wr_d = !i_chip_sel_n && !i_store_strobe_n;
        rd_start = rd_d && !rd_q;
        // data taken at strobe release, where setup to the rising strobe is guaranteed
        wr_end = wr_q && !wr_d;
    end

    always_comb begin
        quad_s1_d = {i_cmp.quad_hi, i_cmp.quad_lo};
        quad_s2_d = quad_s1_q;
        quad_h_d = quad_s2_q;
        win_s1_d = i_cmp.within_threshold;
        win_s2_d = win_s1_q;
        neg_s1_d = i_cmp.error_negative;
        neg_s2_d = neg_s1_q;
        if (stctl_q[STSC_ST_EVERY]) begin
            cross_evt = quad_s2_q != quad_h_q;
        end else begin
            cross_evt = quad_s2_q[1] != quad_h_q[1];
        end
    end

    always_comb begin
        status_val = stctl_q & STSC_ST_WMASK;
        status_val[STSC_ST_CROSS] = cross_q;
        status_val[STSC_ST_QUAD_LO] = quad_s2_q[0];
        status_val[STSC_ST_QUAD_HI] = quad_s2_q[1];
        status_val[STSC_ST_WITHIN] = win_s2_q;
        status_val[STSC_ST_ERRNEG] = neg_s2_q;
    end

    always_comb begin
        thresh_d = thresh_q;
        stctl_d = stctl_q;
        trim_d = trim_q;
        rdata_d = rdata_q;
        oe_n_d = !rd_d;
        cross_d = cross_q;
        if (rd_start && addr_q == STSC_ADDR_STATUS) begin
            cross_d = 1'b0;
        end
        if (cross_evt) begin
            cross_d = 1'b1; // set wins over the read clear
        end
        if (rd_start) begin
            case (addr_q)
                STSC_ADDR_THRESH: rdata_d = thresh_q;
                STSC_ADDR_STATUS: rdata_d = status_val;
                STSC_ADDR_TRIM: rdata_d = trim_q;
                default: rdata_d = 8'h00;
            endcase
        end
        if (wr_end) begin
            case (addr_q)
                STSC_ADDR_THRESH: thresh_d = i_muxed_bus & STSC_TH_WMASK;
                STSC_ADDR_STATUS: stctl_d = i_muxed_bus & STSC_ST_WMASK;
                STSC_ADDR_TRIM: trim_d = i_muxed_bus;
                STSC_ADDR_CLEAR: begin
                    thresh_d = STSC_RST_VALUE;
                    stctl_d = STSC_RST_VALUE;
                    trim_d = STSC_RST_VALUE;
                end
                default: trim_d = trim_q;
            endcase
        end
    end

    always_comb begin
        irq_n_d = !cross_d;
        // seek mode always reads as outside the window
        // enable low pulls the pin low, so release only when inside the window in track mode
        out_n_d = win_s2_q && thresh_d[STSC_TH_TRACK];
        mode_d = thresh_d[STSC_TH_TRACK];
        ctl_d.threshold_sel = thresh_d[STSC_TH_SEL_LSB +: 3];
        ctl_d.track_not_seek = thresh_d[STSC_TH_TRACK];
        ctl_d.filter_discharge = thresh_d[STSC_TH_DISCHARGE];
        ctl_d.zero_input_trim_mode = thresh_d[STSC_TH_ZERO_TRIM];
        ctl_d.frame_ratio_sel = stctl_d[STSC_ST_RATIO];
        ctl_d.motor_current_feedback_sw = stctl_d[STSC_ST_MOTOR];
        ctl_d.trim_value = trim_d;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            ale_q <= 1'b0;
            addr_q <= 3'h0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            rdata_q <= 8'h00;
            oe_n_q <= 1'b1;
            thresh_q <= STSC_RST_VALUE;
            stctl_q <= STSC_RST_VALUE;
            trim_q <= STSC_RST_VALUE;
            cross_q <= 1'b0;
            quad_s1_q <= 2'h0;
            quad_s2_q <= 2'h0;
            quad_h_q <= 2'h0;
            win_s1_q <= 1'b0;
            win_s2_q <= 1'b0;
            neg_s1_q <= 1'b0;
            neg_s2_q <= 1'b0;
            irq_n_q <= 1'b1;
            out_n_q <= 1'b0;
            mode_q <= 1'b0;
            ctl_q <= '0;
        end else begin
            ale_q <= ale_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            rdata_q <= rdata_d;
            oe_n_q <= oe_n_d;
            thresh_q <= thresh_d;
            stctl_q <= stctl_d;
            trim_q <= trim_d;
            cross_q <= cross_d;
            quad_s1_q <= quad_s1_d;
            quad_s2_q <= quad_s2_d;
            quad_h_q <= quad_h_d;
            win_s1_q <= win_s1_d;
            win_s2_q <= win_s2_d;
            neg_s1_q <= neg_s1_d;
            neg_s2_q <= neg_s2_d;
            irq_n_q <= irq_n_d;
            out_n_q <= out_n_d;
            mode_q <= mode_d;
            ctl_q <= ctl_d;
        end
    end

    assign o_muxed_bus = rdata_q;
    assign o_muxed_bus_oe_n = oe_n_q;
    assign o_crossing_irq_n = irq_n_q;
    assign o_outside_threshold_n = 1'b0;
    // open drain: pulls low (enable low) when outside or in seek
    assign o_outside_threshold_oe_n = out_n_q;
    assign o_track_not_seek = mode_q;
    assign o_ctl = ctl_q;

endmodule

`default_nettype wire

// file: rtl/stsc_pkg.sv
package stsc_pkg;
    // register addresses (3-bit latched address)
    localparam logic [2:0] STSC_ADDR_THRESH = 3'h4;
    localparam logic [2:0] STSC_ADDR_STATUS = 3'h5;
    localparam logic [2:0] STSC_ADDR_TRIM   = 3'h6;
    localparam logic [2:0] STSC_ADDR_CLEAR  = 3'h7;

    // threshold control field positions
    localparam int STSC_TH_SEL_LSB   = 0;
    localparam int STSC_TH_TRACK     = 4;
    localparam int STSC_TH_DISCHARGE = 5;
    localparam int STSC_TH_ZERO_TRIM = 7;

    // status field positions
    localparam int STSC_ST_CROSS   = 0;
    localparam int STSC_ST_QUAD_LO = 1;
    localparam int STSC_ST_QUAD_HI = 2;
    localparam int STSC_ST_WITHIN  = 3;
    localparam int STSC_ST_RATIO   = 4;
    localparam int STSC_ST_EVERY   = 5;
    localparam int STSC_ST_MOTOR   = 6;
    localparam int STSC_ST_ERRNEG  = 7;

    // trim field positions
    localparam int STSC_TRIM_SIGN = 7;

    // writable masks and reset values
    localparam logic [7:0] STSC_TH_WMASK  = 8'hb7;
    localparam logic [7:0] STSC_ST_WMASK  = 8'h70;
    localparam logic [7:0] STSC_RST_VALUE = 8'h00;

    // frame ratios declared by frame_ratio_sel
    localparam int STSC_RATIO_ONE  = 32;
    localparam int STSC_RATIO_ZERO = 72;

    // analog comparator results from the servo side
    typedef struct packed {
        logic quad_lo;
        logic quad_hi;
        logic within_threshold;
        logic error_negative;
    } stsc_cmp_type;

    // switch and mode controls toward the analog side
    typedef struct packed {
        logic [2:0] threshold_sel;
        logic       track_not_seek;
        logic       filter_discharge;
        logic       zero_input_trim_mode;
        logic       frame_ratio_sel;
        logic       motor_current_feedback_sw;
        logic [7:0] trim_value;
    } stsc_ctl_type;
endpackage

// file: tb/stsc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module stsc_asserts
    import stsc_pkg::*;
(
    // clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_nrst,
    // bus strobes
    input  wire logic         i_chip_sel_n,
    input  wire logic         i_read_strobe_n,
    input  wire logic         i_store_strobe_n,
    // observed outputs
    input  wire logic         o_muxed_bus_oe_n,
    input  wire logic         o_crossing_irq_n,
    input  wire logic         o_outside_threshold_n,
    input  wire logic         o_outside_threshold_oe_n,
    input  wire logic         o_track_not_seek,
    input  wire stsc_ctl_type o_ctl
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    sequence s_rd; !i_chip_sel_n && !i_read_strobe_n; endsequence
    sequence s_rd_idle; i_chip_sel_n || i_read_strobe_n; endsequence
    sequence s_wr_idle; i_chip_sel_n || i_store_strobe_n; endsequence
    property p_mode; o_track_not_seek == o_ctl.track_not_seek; endproperty
    a_mode: assert property (p_mode) else $error("mode pin differs");
    property p_seek; !o_ctl.track_not_seek |-> !o_outside_threshold_oe_n; endproperty
    a_seek: assert property (p_seek) else $error("seek not flagged");
    property p_od; o_outside_threshold_n == 1'b0; endproperty
    a_od: assert property (p_od) else $error("open drain data high");
    property p_rd_oe; s_rd |=> !o_muxed_bus_oe_n; endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("read not driven");
    property p_rd_off; s_rd_idle [*2] |-> o_muxed_bus_oe_n; endproperty
    a_rd_off: assert property (p_rd_off) else $error("bus driven idle");
    property p_ctl_hold; s_wr_idle [*3] |-> $stable(o_ctl); endproperty
    a_ctl_hold: assert property (p_ctl_hold) else $error("ctl moved");
    // only a read may release the flag, so a low irq holds without one
    property p_irq_hold; !o_crossing_irq_n && (i_chip_sel_n || i_read_strobe_n) |=> !o_crossing_irq_n; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
    property p_rst;
        disable iff (1'b0) !i_nrst |=> o_ctl == '0 && o_crossing_irq_n && o_muxed_bus_oe_n;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind stsc_top stsc_asserts u_stsc_asserts (.i_clk_sys, .i_nrst, .i_chip_sel_n, .i_read_strobe_n,
    .i_store_strobe_n, .o_muxed_bus_oe_n, .o_crossing_irq_n, .o_outside_threshold_n,
    .o_outside_threshold_oe_n, .o_track_not_seek, .o_ctl);
`default_nettype wire

// file: tb/stsc_host.sv
`timescale 1ns/1ps
`default_nettype none
module stsc_host (
    // clock and device side
    input  wire logic       i_clk,
    input  wire logic [7:0] i_dev_data,
    input  wire logic       i_dev_oe_n,
    // bus pins
    output logic            o_ale,
    output logic            o_cs_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic [7:0]      o_bus
);
    logic [7:0] hd = 8'h00;
    // released lines show the inverse, never a kindly held copy
    assign o_bus = i_dev_oe_n ? hd : i_dev_data;
    initial begin
        o_ale = 1'b0;
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
    end
    task automatic addr(input logic [2:0] a);
        @(posedge i_clk) #1;
        hd = {5'h00, a};
        o_ale = 1'b1;
        @(posedge i_clk) #1;
        o_ale = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr(a);
        hd = d;
        o_cs_n = 1'b0;
        o_wr_n = 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        o_wr_n = 1'b1;
        @(posedge i_clk) #1;
        o_cs_n = 1'b1;
        hd = ~d;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        int n = 0;
        addr(a);
        hd = ~hd;
        o_cs_n = 1'b0;
        o_rd_n = 1'b0;
        do begin
            @(posedge i_clk) #1;
            n++;
        end while (i_dev_oe_n && n < 8);
        d = i_dev_oe_n ? 8'hxx : i_dev_data;
        o_rd_n = 1'b1;
        o_cs_n = 1'b1;
        repeat (2) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// file: tb/tb_servo_track_status_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_servo_track_status_control
    import stsc_pkg::*;
;
    logic         i_clk_sys = 1'b0;
    logic         i_nrst = 1'b0;
    logic         i_addr_latch_strobe, i_chip_sel_n, i_read_strobe_n, i_store_strobe_n;
    logic [7:0]   i_muxed_bus, o_muxed_bus;
    logic         o_muxed_bus_oe_n, o_crossing_irq_n, o_outside_threshold_n;
    logic         o_outside_threshold_oe_n, o_track_not_seek;
    stsc_cmp_type i_cmp = '0;
    stsc_ctl_type o_ctl;
    int           error_cnt = 0;
    int           tests_run = 0;
    always #2.5 i_clk_sys = ~i_clk_sys;
    stsc_top u_stsc_top (.i_clk_sys, .i_nrst, .i_addr_latch_strobe, .i_chip_sel_n, .i_read_strobe_n,
        .i_store_strobe_n, .i_muxed_bus, .o_muxed_bus, .o_muxed_bus_oe_n, .i_cmp, .o_crossing_irq_n,
        .o_outside_threshold_n, .o_outside_threshold_oe_n, .o_track_not_seek, .o_ctl);
    stsc_host u_stsc_host (.i_clk(i_clk_sys), .i_dev_data(o_muxed_bus), .i_dev_oe_n(o_muxed_bus_oe_n),
        .o_ale(i_addr_latch_strobe), .o_cs_n(i_chip_sel_n), .o_rd_n(i_read_strobe_n),
        .o_wr_n(i_store_strobe_n), .o_bus(i_muxed_bus));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (error_cnt == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic [7:0] st(input logic [7:0] rw, input logic f);
        return {i_cmp.error_negative, rw[6:4], i_cmp.within_threshold, i_cmp.quad_hi, i_cmp.quad_lo, f};
    endfunction
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_stsc_host.rd(a, d);
        chk(d, e);
    endtask
    // comparator levels pass two sync flops, so give them time to land
    task automatic setc(input logic [3:0] c);
        @(posedge i_clk_sys) #1;
        i_cmp = c;
        repeat (6) @(posedge i_clk_sys);
    endtask
    initial begin
        repeat (4) @(posedge i_clk_sys);
        #1 i_nrst = 1'b1;
        for (int a = 4; a < 7; a++) rchk(a[2:0], 8'h00);
        chk({7'h00, o_outside_threshold_oe_n}, 8'h00);
        u_stsc_host.wr(STSC_ADDR_THRESH, 8'hff);
        rchk(STSC_ADDR_THRESH, STSC_TH_WMASK);
        chk({o_ctl[15:10], o_track_not_seek, 1'b0}, 8'hfe);
        u_stsc_host.wr(STSC_ADDR_STATUS, 8'hff);
        chk({6'h00, o_ctl.frame_ratio_sel, o_ctl.motor_current_feedback_sw}, 8'h03);
        rchk(STSC_ADDR_STATUS, st(STSC_ST_WMASK, 1'b0));
        u_stsc_host.wr(STSC_ADDR_TRIM, 8'ha5);
        chk(o_ctl.trim_value, 8'ha5);
        rchk(STSC_ADDR_TRIM, 8'ha5);
        rchk(3'h2, 8'h00);
        for (int i = 0; i < 2; i++) begin
            setc(i ? 4'b1100 : 4'b1000);
            chk({7'h00, o_crossing_irq_n}, 8'h00);
            rchk(STSC_ADDR_STATUS, st(8'h70, 1'b1));
            rchk(STSC_ADDR_STATUS, st(8'h70, 1'b0));
            chk({7'h00, o_crossing_irq_n}, 8'h01);
        end
        u_stsc_host.wr(STSC_ADDR_STATUS, 8'h10);
        setc(4'b0100);
        rchk(STSC_ADDR_STATUS, st(8'h10, 1'b0));
        setc(4'b0000);
        rchk(STSC_ADDR_STATUS, st(8'h10, 1'b1));
        setc(4'b0011);
        chk({7'h00, o_outside_threshold_oe_n}, 8'h01);
        rchk(STSC_ADDR_STATUS, st(8'h10, 1'b0));
        u_stsc_host.wr(STSC_ADDR_CLEAR, 8'h5a);
        for (int a = 4; a < 7; a++) rchk(a[2:0], a == 5 ? st(8'h00, 1'b0) : 8'h00);
        chk({7'h00, o_outside_threshold_oe_n}, 8'h00);
        u_stsc_host.wr(STSC_ADDR_THRESH, 8'h37);
        @(posedge i_clk_sys) #1 i_nrst = 1'b0;
        repeat (2) @(posedge i_clk_sys);
        #1 i_nrst = 1'b1;
        rchk(STSC_ADDR_THRESH, 8'h00);
        conclude;
    end
    initial begin
        #20000;
        error_cnt++;
        conclude;
    end
endmodule
`default_nettype wire
